// File: core/rhp_pkg.sv
// Shared constants and types for the resolver host port
`default_nettype none

package rhp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ANGLE_W   = 16;
   localparam int BYTE_W    = 8;
   localparam int FRAME_W   = 24;
   localparam int BUS_W     = 16;
   localparam int DATA7_W   = 7;
   localparam int CFG_IDX_W = 5;
   localparam int CFG_DEPTH = 32;
   localparam int RX_CNT_W  = 4;
   localparam logic [RX_CNT_W-1:0] RX_CNT_ONE  = 4'h1;
   localparam logic [RX_CNT_W-1:0] RX_CNT_FULL = 4'h8;

   // Fastest serial clock the host may run, in MHz
   localparam int SCLK_MAX_MHZ = 25;

   ////////////////////////////////////////////////////////////////////////////
   // Pin vector layout after synchronising
   localparam int PIN_N   = 7;
   localparam int PIN_SPS = 0;
   localparam int PIN_CS  = 1;
   localparam int PIN_RD  = 2;
   localparam int PIN_WR  = 3;
   localparam int PIN_SMP = 4;
   localparam int PIN_MLO = 5;
   localparam int PIN_MHI = 6;
   localparam logic [PIN_N-1:0]  PIN_IDLE  = 7'h4f;
   localparam logic [BYTE_W-1:0] DATA_IDLE = 8'h00;

   // Bus lines reused by the serial port
   localparam int LINE_SDI = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses and byte layout
   localparam int ADDR_FLAG_BIT = 7;
   localparam logic [BYTE_W-1:0] ADDR_POS_HI   = 8'h80;
   localparam logic [BYTE_W-1:0] ADDR_POS_LO   = 8'h81;
   localparam logic [BYTE_W-1:0] ADDR_VEL_HI   = 8'h82;
   localparam logic [BYTE_W-1:0] ADDR_VEL_LO   = 8'h83;
   localparam logic [BYTE_W-1:0] ADDR_RW_FIRST = 8'h88;
   localparam logic [BYTE_W-1:0] ADDR_CONTROL  = 8'h92;
   localparam logic [BYTE_W-1:0] ADDR_SOFT_RST = 8'hf0;
   localparam logic [BYTE_W-1:0] ADDR_FAULT    = 8'hff;
   localparam logic [CFG_IDX_W-1:0] CTRL_IDX   = 5'h12;
   localparam logic [DATA7_W-1:0] CTRL_RESET   = 7'h7e;
   localparam logic [DATA7_W-1:0] CFG_RESET    = 7'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Resolution code in control bits 1:0 and the matching data masks
   localparam logic [1:0] RES_10 = 2'h0;
   localparam logic [1:0] RES_12 = 2'h1;
   localparam logic [1:0] RES_14 = 2'h2;
   localparam logic [ANGLE_W-1:0] MASK_10 = 16'hffc0;
   localparam logic [ANGLE_W-1:0] MASK_12 = 16'hfff0;
   localparam logic [ANGLE_W-1:0] MASK_14 = 16'hfffc;
   localparam logic [ANGLE_W-1:0] MASK_16 = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Fault bits feeding each indicator, and the fault state out of reset
   localparam logic [BYTE_W-1:0] LOT_MASK     = 8'h4e;
   localparam logic [BYTE_W-1:0] DOS_MASK     = 8'hf1;
   localparam logic [BYTE_W-1:0] FAULT_RESET  = 8'h40;

   typedef enum logic [1:0] {
      RHP_MODE_POS  = 2'b00,
      RHP_MODE_VEL  = 2'b01,
      RHP_MODE_RSVD = 2'b10,
      RHP_MODE_CFG  = 2'b11
   } rhp_mode_t;

endpackage

`default_nettype wire

// File: core/rhp_sync.sv
// Two-stage synchroniser for a group of pin levels
`default_nettype none

module rhp_sync #(
   parameter int                WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stab_r;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clock) begin
            if (rst) begin
               meta_r[g] <= RST_VAL[g];
               stab_r[g] <= RST_VAL[g];
            end else begin
               meta_r[g] <= d[g];
               stab_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign q = stab_r;

endmodule

`default_nettype wire

// File: core/rhp_serial_link.sv
// Serial shifter running on the host's serial clock
`default_nettype none

module rhp_serial_link
   import rhp_pkg::*;
(
   input  wire logic               serial_clock,
   input  wire logic               frame_n,
   input  wire logic               serial_in,
   input  wire logic [FRAME_W-1:0] tx_word,
   output logic                    serial_out,
   output logic                    serial_out_oe_n,
   output logic [BYTE_W-1:0]       rx_byte,
   output logic                    rx_full
);

   logic                 out_oe_n_r;
   logic                 sdo_r;
   logic [FRAME_W-1:0]   tx_shift_r;
   logic                 rx_first_r;
   logic [BYTE_W-1:0]    rx_shift_r;
   logic [RX_CNT_W-1:0]  rx_cnt_r;

   ////////////////////////////////////////////////////////////////////////////
   // Driver enable: released by the frame itself even if the clock stops
   always_ff @(posedge serial_clock or posedge frame_n) begin
      if (frame_n) begin
         out_oe_n_r <= 1'b1;   // R21
      end else begin
         out_oe_n_r <= 1'b0;   // R21
      end
   end

   // First rising edge of a frame takes the quasi-static output word
   always_ff @(posedge serial_clock) begin
      if (!frame_n) begin
         if (out_oe_n_r) begin
            sdo_r      <= tx_word[FRAME_W-1];   // R25
            tx_shift_r <= {tx_word[FRAME_W-2:0], 1'b0};
         end else begin
            sdo_r      <= tx_shift_r[FRAME_W-1];   // R23
            tx_shift_r <= {tx_shift_r[FRAME_W-2:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive side: capture on falling edges, keep the last eight bits
   always_ff @(negedge serial_clock or posedge frame_n) begin
      if (frame_n) begin
         rx_first_r <= 1'b1;
      end else begin
         rx_first_r <= 1'b0;
      end
   end

   always_ff @(negedge serial_clock) begin
      if (!frame_n) begin
         rx_shift_r <= {rx_shift_r[BYTE_W-2:0], serial_in};   // R25
      end
   end

   // Count survives the frame end so the core can check it afterwards
   always_ff @(negedge serial_clock) begin
      if (!frame_n) begin
         if (rx_first_r) begin
            rx_cnt_r <= RX_CNT_ONE;
         end else if (rx_cnt_r != RX_CNT_FULL) begin
            rx_cnt_r <= RX_CNT_W'(rx_cnt_r + RX_CNT_ONE);
         end
      end
   end

   assign serial_out      = sdo_r;
   assign serial_out_oe_n = out_oe_n_r;
   assign rx_byte         = rx_shift_r;
   assign rx_full         = (rx_cnt_r == RX_CNT_FULL);

endmodule

`default_nettype wire

// File: core/rhp_host_port.sv
// Host-facing parallel and serial port of the resolver converter
//
// Overview of operation
// [R1] Host keeps the serial clock at or below 25 MHz; the test host model clocks it with a 12 ns period (about 83 MHz).
// [R2] Select high uses parallel port; low uses serial and floats lines 0 to 12.
// [R3] Serial mode: line 13 clock, 14 data in, 15 data out, write strobe frames.
// [R4] Holding registers load only on capture strobe fall; host holds it low long enough.
// [R5] Position is unsigned, 10 to 16 bits by resolution.
// [R6] Velocity is twos complement, 10 to 16 bits, sign gives direction.
// [R7] Host holds chip select low for parallel access.
// [R8] Written byte with bit 7 set is an address, otherwise data.
// [R9] Config mode: address byte on one strobe rise, data byte on the next.
// [R10] Host keeps read strobe high during parallel writes.
// [R11] Position and velocity read in any mode; other registers only in config.
// [R12] Address write loads output register; read/write bytes carry parity error in bit 7.
// [R13] Host captures before reading position or velocity in config mode.
// [R14] Fault register refreshes on each capture strobe fall.
// [R15] Normal mode picks position or velocity by mode inputs while chip select low.
// [R16] Drive bus only with chip select and read low; host waits between reads.
// [R17] Host keeps write strobe high while read strobe is low.
// [R18] Eight fault bits; faults pull tracking-loss or degrade outputs low.
// [R19] Capture, read fault register, capture again clears indicators; persisting faults return.
// [R20] Last valid address survives leaving and reentering config mode.
// [R21] Serial data pins leave high impedance in frame, return at frame end.
// [R22] Host holds chip select low in serial mode.
// [R23] Normal serial frame: 24 bits, MSB first, 16 angular then 8 fault.
// [R24] Config serial read returns one 8-bit register byte.
// [R25] Output shifts on rising serial clock, input captured on falling.
// [R26] Data byte without a valid latched address is ignored.
`default_nettype none

module rhp_host_port
   import rhp_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               serial_clock,
   input  wire logic               serial_port_select_n,
   input  wire logic               chip_select_n,
   input  wire logic               read_strobe_n,
   input  wire logic               write_frame_strobe_n,
   input  wire logic               sample_n,
   input  wire logic               mode_select_low,
   input  wire logic               mode_select_high,
   input  wire logic [BUS_W-1:0]   data_bus_in,
   input  wire logic [ANGLE_W-1:0] loop_position,
   input  wire logic [ANGLE_W-1:0] loop_velocity,
   input  wire logic [BYTE_W-1:0]  fault_detect,
   output logic      [BUS_W-1:0]   data_bus_out,
   output logic      [BUS_W-1:0]   data_bus_oe_n,
   output logic                    serial_data_out,
   output logic                    serial_data_oe_n,
   output logic                    tracking_loss_n,
   output logic                    signal_degrade_n,
   output logic      [DATA7_W-1:0] control_word,
   output logic                    soft_reset_pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   logic [PIN_N-1:0]  pin_raw;
   logic [PIN_N-1:0]  pin_q;
   logic [PIN_N-1:0]  pin_d_r;
   logic [BYTE_W-1:0] data_q;

   always_comb begin
      pin_raw          = '0;
      pin_raw[PIN_SPS] = serial_port_select_n;
      pin_raw[PIN_CS]  = chip_select_n;
      pin_raw[PIN_RD]  = read_strobe_n;
      pin_raw[PIN_WR]  = write_frame_strobe_n;
      pin_raw[PIN_SMP] = sample_n;
      pin_raw[PIN_MLO] = mode_select_low;
      pin_raw[PIN_MHI] = mode_select_high;
   end

   rhp_sync #(
      .WIDTH   (PIN_N),
      .RST_VAL (PIN_IDLE)
   ) u_pin_sync (
      .clock (clock),
      .rst   (rst),
      .d     (pin_raw),
      .q     (pin_q)
   );

   // Data lines share the strobe latency so bytes line up with edges
   rhp_sync #(
      .WIDTH   (BYTE_W),
      .RST_VAL (DATA_IDLE)
   ) u_data_sync (
      .clock (clock),
      .rst   (rst),
      .d     (data_bus_in[BYTE_W-1:0]),
      .q     (data_q)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_d_r <= PIN_IDLE;
      end else begin
         pin_d_r <= pin_q;
      end
   end

   logic      parallel;
   logic      cs_low;
   logic      rd_low;
   logic      busy;
   logic      sample_fall;
   logic      wr_rise;
   logic      rd_rise;
   rhp_mode_t mode;
   logic      config_mode;

   assign parallel    = pin_q[PIN_SPS];   // R2
   assign cs_low      = ~pin_q[PIN_CS];
   assign rd_low      = ~pin_q[PIN_RD];
   assign busy        = rd_low | ~pin_q[PIN_WR];
   assign sample_fall = pin_d_r[PIN_SMP] & ~pin_q[PIN_SMP];   // R4
   assign wr_rise     = ~pin_d_r[PIN_WR] & pin_q[PIN_WR];
   assign rd_rise     = ~pin_d_r[PIN_RD] & pin_q[PIN_RD];
   assign mode        = rhp_mode_t'({pin_q[PIN_MHI], pin_q[PIN_MLO]});
   assign config_mode = (mode == RHP_MODE_CFG);

   ////////////////////////////////////////////////////////////////////////////
   // Serial link in the serial clock domain

   logic                link_frame_n;
   logic [FRAME_W-1:0]  out_r;
   logic [BYTE_W-1:0]   rx_byte;
   logic                rx_full;

   // Parallel strobes must never open the serial driver
   assign link_frame_n = write_frame_strobe_n | serial_port_select_n;   // R3

   rhp_serial_link u_link (
      .serial_clock    (serial_clock),
      .frame_n         (link_frame_n),
      .serial_in       (data_bus_in[LINE_SDI]),
      .tx_word         (out_r),
      .serial_out      (serial_data_out),
      .serial_out_oe_n (serial_data_oe_n),
      .rx_byte         (rx_byte),
      .rx_full         (rx_full)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Byte writes: address or data

   logic                 wr_event;
   logic [BYTE_W-1:0]    wr_byte;
   logic                 wr_is_addr;
   logic [BYTE_W-1:0]    addr_r;
   logic                 addr_valid_r;
   logic [DATA7_W-1:0]   cfg_data_r [CFG_DEPTH];
   logic [CFG_DEPTH-1:0] cfg_par_r;
   logic [CFG_IDX_W-1:0] addr_idx;
   logic                 addr_is_rw;

   // A serial frame counts as a write only if a whole byte came in
   assign wr_event   = config_mode & wr_rise &
                       ((parallel & cs_low & ~rd_low) | (~parallel & rx_full));   // R9
   assign wr_byte    = parallel ? data_q : rx_byte;
   assign wr_is_addr = wr_byte[ADDR_FLAG_BIT];   // R8
   assign addr_idx   = addr_r[CFG_IDX_W-1:0];
   assign addr_is_rw = (addr_r >= ADDR_RW_FIRST) && (addr_r <= ADDR_CONTROL);

   function automatic logic rhp_addr_known(input logic [BYTE_W-1:0] a);
      rhp_addr_known = (a == ADDR_POS_HI) || (a == ADDR_POS_LO) ||
                       (a == ADDR_VEL_HI) || (a == ADDR_VEL_LO) ||
                       (a == ADDR_FAULT)  ||
                       ((a >= ADDR_RW_FIRST) && (a <= ADDR_CONTROL));
   endfunction

   // Address kept across mode changes
   always_ff @(posedge clock) begin
      if (rst) begin
         addr_r       <= ADDR_FAULT;
         addr_valid_r <= 1'b0;
      end else if (wr_event && wr_is_addr && rhp_addr_known(wr_byte)) begin
         addr_r       <= wr_byte;   // R20
         addr_valid_r <= 1'b1;      // R20
      end
   end

   // Stored parity is checked against the data on every read/write register readback
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < CFG_DEPTH; i++) begin
            cfg_data_r[i] <= (i == int'(CTRL_IDX)) ? CTRL_RESET : CFG_RESET;
            cfg_par_r[i]  <= (i == int'(CTRL_IDX)) ? (^CTRL_RESET) : (^CFG_RESET);
         end
      end else if (wr_event && !wr_is_addr && addr_valid_r && addr_is_rw) begin   // R26
         cfg_data_r[addr_idx] <= wr_byte[DATA7_W-1:0];     // R8
         cfg_par_r[addr_idx]  <= ^wr_byte[DATA7_W-1:0];    // R12
      end
   end

   logic soft_reset_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         soft_reset_r <= 1'b0;
      end else begin
         soft_reset_r <= wr_event & wr_is_addr & (wr_byte == ADDR_SOFT_RST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holding registers for position and velocity

   logic [ANGLE_W-1:0] res_mask;
   logic [ANGLE_W-1:0] pos_r;
   logic [ANGLE_W-1:0] vel_r;

   always_comb begin
      unique case (cfg_data_r[CTRL_IDX][1:0])
         RES_10:  res_mask = MASK_10;
         RES_12:  res_mask = MASK_12;
         RES_14:  res_mask = MASK_14;
         default: res_mask = MASK_16;
      endcase
   end

   // Unused low bits read zero; left-aligned velocity keeps its sign in bit 15
   always_ff @(posedge clock) begin
      if (rst) begin
         pos_r <= '0;
         vel_r <= '0;
      end else if (sample_fall) begin
         pos_r <= loop_position & res_mask;   // R5
         vel_r <= loop_velocity & res_mask;   // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault register, sticky faults and indicators

   logic [BYTE_W-1:0] fault_hold_r;
   logic [BYTE_W-1:0] fault_hold_nxt;
   logic [BYTE_W-1:0] fault_reg_r;
   logic              fault_read_r;
   logic              fault_read_set;
   logic              lot_n_r;
   logic              dos_n_r;

   // New detections always survive a clear
   always_comb begin
      if (soft_reset_r) begin
         fault_hold_nxt = fault_detect;
      end else if (sample_fall && fault_read_r) begin
         fault_hold_nxt = fault_detect;                  // R19
      end else begin
         fault_hold_nxt = fault_hold_r | fault_detect;   // R18
      end
   end

   assign fault_read_set = config_mode & addr_valid_r & (addr_r == ADDR_FAULT) &
                           ((parallel & cs_low & rd_rise) | (~parallel & wr_rise));

   always_ff @(posedge clock) begin
      if (rst) begin
         fault_hold_r <= FAULT_RESET;
         lot_n_r      <= 1'b0;
         dos_n_r      <= 1'b0;
      end else begin
         fault_hold_r <= fault_hold_nxt;
         lot_n_r      <= ~|(fault_hold_nxt & LOT_MASK);   // R18
         dos_n_r      <= ~|(fault_hold_nxt & DOS_MASK);   // R18
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         fault_reg_r <= FAULT_RESET;
      end else if (soft_reset_r) begin
         fault_reg_r <= '0;
      end else if (sample_fall) begin
         fault_reg_r <= fault_hold_r | fault_detect;   // R14
      end
   end

   // Read flag: set wins over the clearing capture edge
   always_ff @(posedge clock) begin
      if (rst) begin
         fault_read_r <= 1'b0;
      end else if (fault_read_set) begin
         fault_read_r <= 1'b1;   // R19
      end else if (sample_fall) begin
         fault_read_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output register

   logic [BYTE_W-1:0] cfg_byte;

   always_comb begin
      unique case (addr_r)
         ADDR_POS_HI: cfg_byte = pos_r[ANGLE_W-1:BYTE_W];
         ADDR_POS_LO: cfg_byte = pos_r[BYTE_W-1:0];
         ADDR_VEL_HI: cfg_byte = vel_r[ANGLE_W-1:BYTE_W];
         ADDR_VEL_LO: cfg_byte = vel_r[BYTE_W-1:0];
         ADDR_FAULT:  cfg_byte = fault_reg_r;
         default:     cfg_byte = {(^cfg_data_r[addr_idx]) ^ cfg_par_r[addr_idx],
                                  cfg_data_r[addr_idx]};   // R12
      endcase
   end

   // Frozen while a read or frame runs, so both ports see a steady word
   always_ff @(posedge clock) begin
      if (rst) begin
         out_r <= '0;
      end else if (!busy) begin
         if (config_mode) begin
            if (addr_valid_r) begin
               out_r <= {cfg_byte, {ANGLE_W{1'b0}}};   // R24
            end
         end else if (cs_low) begin
            if (mode == RHP_MODE_VEL) begin
               out_r <= {vel_r, fault_reg_r};   // R15
            end else begin
               out_r <= {pos_r, fault_reg_r};   // R23
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parallel bus drivers

   logic [BUS_W-1:0] bus_out_r;
   logic [BUS_W-1:0] bus_oe_n_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         bus_out_r  <= '0;
         bus_oe_n_r <= '1;
      end else if (parallel && cs_low && rd_low) begin
         if (bus_oe_n_r[0]) begin
            if (config_mode) begin
               bus_out_r <= {{BYTE_W{1'b0}}, out_r[FRAME_W-1:ANGLE_W]};   // R11
            end else begin
               bus_out_r <= out_r[FRAME_W-1:BYTE_W];                      // R11
            end
         end
         bus_oe_n_r <= '0;   // R16
      end else begin
         bus_oe_n_r <= '1;   // R2
      end
   end

   assign data_bus_out     = bus_out_r;
   assign data_bus_oe_n    = bus_oe_n_r;
   assign tracking_loss_n  = lot_n_r;
   assign signal_degrade_n = dos_n_r;
   assign control_word     = cfg_data_r[CTRL_IDX];
   assign soft_reset_pulse = soft_reset_r;

endmodule

`default_nettype wire

// File: test/rhp_host_port_assertions.sv
// Pin-level checks for the resolver host port
`default_nettype none
module rhp_host_port_chk
   import rhp_pkg::*;
(
   input wire logic               clock,
   input wire logic               rst,
   input wire logic               serial_clock,
   input wire logic               serial_port_select_n,
   input wire logic               chip_select_n,
   input wire logic               read_strobe_n,
   input wire logic               write_frame_strobe_n,
   input wire logic               sample_n,
   input wire logic               mode_select_low,
   input wire logic               mode_select_high,
   input wire logic [BYTE_W-1:0]  fault_detect,
   input wire logic [BUS_W-1:0]   data_bus_oe_n,
   input wire logic               serial_data_oe_n,
   input wire logic               tracking_loss_n,
   input wire logic               signal_degrade_n,
   input wire logic [DATA7_W-1:0] control_word
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////
   AST_SER_FLOAT: assert property (@(posedge clock) disable iff (rst)
      !serial_port_select_n [*5] |-> &data_bus_oe_n) else $error("bus driven serial");
   AST_RD_RELEASE: assert property (@(posedge clock) disable iff (rst)
      (read_strobe_n || chip_select_n) [*5] |-> &data_bus_oe_n) else $error("bus not released");
   AST_RD_DRIVE: assert property (@(posedge clock) disable iff (rst)
      (!read_strobe_n && !chip_select_n && serial_port_select_n) [*5] |-> data_bus_oe_n == '0)
      else $error("bus not driven");
   AST_FRAME_END: assert property (@(posedge clock) disable iff (rst)
      $rose(write_frame_strobe_n) |-> serial_data_oe_n) else $error("sdo after frame");
   AST_SDO_IN_FRAME: assert property (@(posedge serial_clock) disable iff (rst)
      !serial_data_oe_n |-> !write_frame_strobe_n) else $error("sdo outside frame");
   AST_LOSS_SET: assert property (@(posedge clock) disable iff (rst)
      (|(fault_detect & LOT_MASK)) [*5] |-> !tracking_loss_n) else $error("no tracking loss");
   AST_DEGRADE_SET: assert property (@(posedge clock) disable iff (rst)
      (|(fault_detect & DOS_MASK)) [*5] |-> !signal_degrade_n) else $error("no degrade");
   AST_CLEAR_CAUSE: assert property (@(posedge clock) disable iff (rst)
      ($rose(tracking_loss_n) || $rose(signal_degrade_n)) |-> $past(sample_n, 6) && !$past(sample_n, 3))
      else $error("clear without capture");
   AST_CFG_ONLY: assert property (@(posedge clock) disable iff (rst)
      $changed(control_word) |-> $past(mode_select_low, 3) && $past(mode_select_high, 3))
      else $error("control outside config");
endmodule

bind rhp_host_port rhp_host_port_chk u_chk (.*);
`default_nettype wire

// File: test/rhp_host_model.sv
// Host serial master that frames transfers on the link
`default_nettype none
module rhp_host_model (
   output logic      serial_clock,
   output logic      frame_n,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {serial_clock, frame_n, sdi} = 3'b010;
   // Clock idles low; last 8 SDI bits form the byte
   task automatic frame(input int n, input logic [7:0] tx, output logic [23:0] rx);
      rx = '0;
      frame_n = 1'b0;
      #7;
      for (int i = 0; i < n; i++) begin
         serial_clock = 1'b1;
         sdi = (i >= n - 8) ? tx[n - 1 - i] : ~sdi;
         #6 serial_clock = 1'b0;
         rx = {rx[22:0], sdo_oe_n ? 1'bx : sdo};
         #6;
      end
      frame_n = 1'b1;
      sdi = ~sdi;
   endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the resolver host port
`default_nettype none
module tb
   import rhp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst, serial_clock, serial_port_select_n, chip_select_n, read_strobe_n, write_frame_strobe_n;
   logic sample_n, mode_select_low, mode_select_high, sdi, frm_n, wr_n, serial_data_out, serial_data_oe_n;
   logic tracking_loss_n, signal_degrade_n, soft_reset_pulse;
   logic [BYTE_W-1:0]  fault_detect, wbyte;
   logic [ANGLE_W-1:0] loop_position, loop_velocity, ev, got;
   logic [BUS_W-1:0]   data_bus_in, data_bus_out, data_bus_oe_n;
   logic [DATA7_W-1:0] control_word, cw_exp;
   logic [23:0]        rx;
   int                 n_fail = 0, checks = 0;

   assign write_frame_strobe_n = wr_n & frm_n;
   assign data_bus_in = (data_bus_oe_n & {1'b0, sdi, serial_clock, 5'h00, wbyte}) | (~data_bus_oe_n & data_bus_out);

   rhp_host_port dut (.clock, .rst, .serial_clock, .serial_port_select_n, .chip_select_n, .read_strobe_n,
      .write_frame_strobe_n, .sample_n, .mode_select_low, .mode_select_high, .data_bus_in, .loop_position,
      .loop_velocity, .fault_detect, .data_bus_out, .data_bus_oe_n, .serial_data_out, .serial_data_oe_n,
      .tracking_loss_n, .signal_degrade_n, .control_word, .soft_reset_pulse);
   rhp_host_model host (.serial_clock, .frame_n(frm_n), .sdi, .sdo(serial_data_out), .sdo_oe_n(serial_data_oe_n));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %0t %h %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Resolution mask
   function automatic logic [15:0] mask();
      return 16'hffff << (6 - 2 * int'(cw_exp[1:0]));
   endfunction
   task automatic capture();
      loop_position = 16'($urandom);
      loop_velocity = 16'($urandom);
      sample_n = 1'b0;
      cyc(5);
      sample_n = 1'b1;
      cyc(8);
   endtask
   task automatic mode(input logic [1:0] m);
      {mode_select_high, mode_select_low} = m;
      cyc(6);
   endtask
   task automatic wr(input logic [7:0] b);
      wbyte = b;
      wr_n = 1'b0;
      cyc(4);
      wr_n = 1'b1;
      cyc(6);
   endtask
   task automatic rd(output logic [15:0] d);
      int i;
      read_strobe_n = 1'b0;
      for (i = 0; i < 10 && data_bus_oe_n !== 16'h0000; i++)
         cyc(1);
      if (i == 10) begin
         n_fail++;
         finish_test();
      end
      cyc(3);
      d = data_bus_out;
      read_strobe_n = 1'b1;
      cyc(6);
      check(data_bus_oe_n, 16'hffff);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'he237));
      rst = 1'b1;
      {serial_port_select_n, read_strobe_n, wr_n, sample_n} = 4'hf;
      {chip_select_n, mode_select_low, mode_select_high} = 3'h0;
      {loop_position, loop_velocity, fault_detect, wbyte} = '0;
      cw_exp = CTRL_RESET;
      cyc(16);
      rst = 1'b0;
      cyc(4);
      check(control_word, CTRL_RESET);
      check({tracking_loss_n, signal_degrade_n, soft_reset_pulse}, 3'b000);
      capture();
      for (int m = 0; m < 3; m++) begin
         mode(2'(m));
         rd(got);
         check(got, (m == 1) ? loop_velocity & mask() : loop_position & mask());
      end
      $display("normal read done");
      mode(2'b11);
      wr(8'h33);
      check(control_word, CTRL_RESET);
      wr(ADDR_CONTROL);
      rd(got);
      check(got, {9'h000, CTRL_RESET});
      wr(8'h05);
      cw_exp = 7'h05;
      check(control_word, cw_exp);
      wr(ADDR_CONTROL);
      rd(got);
      check(got, 16'h0005);
      capture();
      for (int a = 0; a < 4; a++) begin
         wr(8'(ADDR_POS_HI + a));
         ev = (a < 2) ? loop_position & mask() : loop_velocity & mask();
         rd(got);
         check(got, {8'h00, a[0] ? ev[7:0] : ev[15:8]});
      end
      mode(2'b00);
      mode(2'b11);
      rd(got);
      check(got, {8'h00, ev[7:0]});
      $display("config read done");
      capture();
      wr(ADDR_FAULT);
      rd(got);
      check(got, 16'h0040);
      capture();
      fault_detect = 8'h18;
      cyc(6);
      fault_detect = 8'h00;
      cyc(6);
      check({tracking_loss_n, signal_degrade_n}, 2'b00);
      capture();
      wr(ADDR_FAULT);
      rd(got);
      check(got, 16'h0018);
      capture();
      check({tracking_loss_n, signal_degrade_n}, 2'b11);
      $display("fault done");
      serial_port_select_n = 1'b0;
      mode(2'b00);
      capture();
      host.frame(24, 8'h00, rx);
      check(rx, {loop_position & mask(), 8'h00});
      check(data_bus_oe_n, 16'hffff);
      mode(2'b11);
      host.frame(8, ADDR_CONTROL, rx);
      cyc(6);
      host.frame(8, 8'h0a, rx);
      check(rx[7:0], 8'h05);
      cyc(6);
      check(control_word, 7'h0a);
      $display("serial done");
      finish_test();
   end
endmodule
`default_nettype wire
